// ---- hw/frame_copy_check.sv ----
// frame copy decision: internal address compare plus external checker lines
// Overview of operation
// - compare destination address of every frame, stripped too
// - external verdict runs beside internal compare
// - accept specific address only with its own U/L value
// - buffer while checking, reclaim when not copied
// - verdict lines released when idle
// - both lines low on first word write
// - frame words written at consecutive addresses
// - decide only after both checks finish
// - verdict four bytes before first buffer end
// - lines only driven low, wired-AND
// - fail beats external match only, internal match still copies; idle lines leave the frame undecided
// - no buffer: write to fixed address until verdict
// - express-only option: no external copy, still flag
`timescale 1ns/1ps
module frame_copy_check
   import frame_copy_pkg::*;
(
   input wire logic ref_clk, // 10 MHz adapter bus clock
   input wire logic resetn, // async reset, active low
   input wire logic clk_en, // freezes all state when low
   input wire logic frame_start, // pulse: new frame received
   input wire logic word_valid, // pulse: receive word ready
   input wire logic [WORD_W-1:0] word_data, // receive word
   input wire logic word_last, // with word_valid: last word of frame
   input wire logic dest_valid, // pulse: dest address complete
   input wire logic [47:0] dest_addr, // received destination address
   input wire logic [47:0] station_addr, // specific address incl high word
   input wire logic buffer_free, // a receive buffer is available
   input wire logic [ADDR_W-1:0] buffer_base, // first buffer start
   input wire logic [LEN_W-1:0] buffer_len, // first buffer length, bytes
   input wire logic [1:0] receive_copy_option, // copy option
   input wire logic bus_ready, // write accepted this cycle
   output dma_write_t dma_wr, // receive DMA write
   input wire logic external_match_line_in, // pin level
   output logic external_match_line_out, // always zero
   output logic external_match_line_oe, // pull low when high
   input wire logic external_fail_line_in, // pin level
   output logic external_fail_line_out, // always zero
   output logic external_fail_line_oe, // pull low when high
   output logic word_ready, // may accept next word
   output logic result_valid, // pulse: frame decided
   output frame_result_t result, // decision of the frame
   output logic [1:0] address_recognised_bits // bits set in frame
);

   typedef enum {S_IDLE, S_FIRST, S_WAIT, S_CHECK, S_DONE} state_t;

   // pin synchronisers: three flops, accept when last two agree
   logic [2:0] match_sync_r, match_sync_nxt;
   logic [2:0] fail_sync_r, fail_sync_nxt;
   logic match_low_r, match_low_nxt;
   logic fail_low_r, fail_low_nxt;

   state_t state_r, state_nxt;
   logic [ADDR_W-1:0] wr_addr_r, wr_addr_nxt;
   logic [LEN_W-1:0] bytes_r, bytes_nxt;
   logic no_buf_r, no_buf_nxt;
   logic int_done_r, int_done_nxt;
   logic int_hit_r, int_hit_nxt;
   logic ext_done_r, ext_done_nxt;
   logic ext_match_r, ext_match_nxt;
   logic ext_fail_r, ext_fail_nxt;
   logic last_seen_r, last_seen_nxt;
   logic late_r, late_nxt;
   logic drive_r, drive_nxt;
   logic [2:0] settle_r, settle_nxt;
   dma_write_t wr_r, wr_nxt;
   frame_result_t res_r, res_nxt;
   logic res_v_r, res_v_nxt;
   logic [1:0] ari_r, ari_nxt;

   logic [47:0] cmp_station;
   logic int_hit_now;
   logic ext_copy;
   logic pending;
   logic verdict_seen;
   logic [LEN_W-1:0] limit;

   // synchroniser next values; stage 0 is read only by stage 1
   always_comb begin
      match_sync_nxt = {match_sync_r[1:0], external_match_line_in};
      fail_sync_nxt = {fail_sync_r[1:0], external_fail_line_in};
      match_low_nxt = match_low_r;
      fail_low_nxt = fail_low_r;
      if (match_sync_r[2] == match_sync_r[1]) begin
         match_low_nxt = ~match_sync_r[2];
      end
      if (fail_sync_r[2] == fail_sync_r[1]) begin
         fail_low_nxt = ~fail_sync_r[2];
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         match_sync_r <= 3'h7;
         fail_sync_r <= 3'h7;
         match_low_r <= 1'b0;
         fail_low_r <= 1'b0;
      end else if (clk_en) begin
         match_sync_r <= match_sync_nxt;
         fail_sync_r <= fail_sync_nxt;
         match_low_r <= match_low_nxt;
         fail_low_r <= fail_low_nxt;
      end
   end

   // U/L bit is compared like any other bit, so only the exact U/L value matches
   always_comb begin
      cmp_station = station_addr;
      int_hit_now = (dest_addr == cmp_station);
   end

   // limit: last byte count at which a verdict is still in time
   assign limit = buffer_len - VERDICT_MARGIN_BYTES;
   // the decision is held off while either check is unfinished
   assign pending = !(int_done_r && ext_done_r);
   // wait for our own low pulse to drain; both low reads as fail
   assign verdict_seen = (settle_r == SYNC_SETTLE) &&
                         (match_low_r || fail_low_r);
   // external copy is blocked by the express-only option
   assign ext_copy = ext_match_r && !ext_fail_r &&
                     (receive_copy_option != COPY_OPT_EXPRESS_ONLY);
   // words are held off while the first write still drives the lines
   assign word_ready = (state_r == S_FIRST || state_r == S_CHECK) &&
                       (!wr_r.valid || bus_ready);

   // frame sequencing, DMA address stepping and decision
   always_comb begin
      state_nxt = state_r;
      wr_addr_nxt = wr_addr_r;
      bytes_nxt = bytes_r;
      no_buf_nxt = no_buf_r;
      int_done_nxt = int_done_r;
      int_hit_nxt = int_hit_r;
      ext_done_nxt = ext_done_r;
      ext_match_nxt = ext_match_r;
      ext_fail_nxt = ext_fail_r;
      last_seen_nxt = last_seen_r;
      late_nxt = late_r;
      drive_nxt = 1'b0;
      settle_nxt = settle_r;
      wr_nxt = wr_r;
      res_nxt = res_r;
      res_v_nxt = 1'b0;
      ari_nxt = ari_r;
      if (wr_r.valid && bus_ready) begin
         wr_nxt.valid = 1'b0;
      end
      if (dest_valid && state_r != S_IDLE) begin
         int_done_nxt = 1'b1;
         int_hit_nxt = int_hit_now;
      end
      if (state_r == S_CHECK && !ext_done_r && verdict_seen) begin
         ext_done_nxt = 1'b1;
         ext_match_nxt = match_low_r && !fail_low_r;
         ext_fail_nxt = fail_low_r;
         if (bytes_r > limit) begin
            late_nxt = 1'b1;
         end
      end
      case (state_r)
         S_IDLE: begin
            if (frame_start) begin
               state_nxt = S_FIRST;
               no_buf_nxt = !buffer_free;
               wr_addr_nxt = buffer_free ? buffer_base : NO_BUFFER_ADDR;
               bytes_nxt = COUNT_RESET;
               int_done_nxt = 1'b0;
               int_hit_nxt = 1'b0;
               ext_done_nxt = 1'b0;
               ext_match_nxt = 1'b0;
               ext_fail_nxt = 1'b0;
               last_seen_nxt = 1'b0;
               late_nxt = 1'b0;
               settle_nxt = 3'h0;
            end
         end
         S_FIRST: begin
            if (word_valid && word_ready) begin
               // first word carries the access and frame control bytes
               wr_nxt = '{valid: 1'b1, addr: wr_addr_r, data: word_data};
               drive_nxt = 1'b1;
               bytes_nxt = BYTES_PER_WORD;
               if (!no_buf_r) begin
                  wr_addr_nxt = wr_addr_r + BYTES_PER_WORD;
               end
               last_seen_nxt = word_last;
               state_nxt = S_WAIT;
            end
         end
         S_WAIT: begin
            // hold both lines until the first write completes on the bus
            drive_nxt = !(wr_r.valid && bus_ready);
            if (!drive_nxt) begin
               state_nxt = S_CHECK;
            end
         end
         S_CHECK: begin
            settle_nxt = settle_r + 3'(settle_r != SYNC_SETTLE);
            if (word_valid && word_ready && !last_seen_r) begin
               // stop writing to the fixed address once verdict is in
               if (!(no_buf_r && ext_done_r)) begin
                  wr_nxt = '{valid: 1'b1, addr: wr_addr_r, data: word_data};
               end
               bytes_nxt = bytes_r + BYTES_PER_WORD;
               if (!no_buf_r) begin
                  wr_addr_nxt = wr_addr_r + BYTES_PER_WORD;
               end
               last_seen_nxt = word_last;
            end
            // decide only when frame ended and both checks finished
            if (last_seen_r && !pending && !wr_r.valid) begin
               state_nxt = S_DONE;
            end
         end
         S_DONE: begin
            // fail beats external match only, an internal match still copies; reached only after a pin verdict, idle pins never get here
            res_nxt.ext_fail = ext_fail_r;
            res_nxt.copy = !no_buf_r && (int_hit_r || ext_copy);
            res_nxt.reclaim = !res_nxt.copy;
            res_nxt.addr_recognised = int_hit_r ||
                                      (ext_match_r && !ext_fail_r);
            res_nxt.late = late_r;
            ari_nxt = {2{res_nxt.addr_recognised}};
            res_v_nxt = 1'b1;
            state_nxt = S_IDLE;
         end
         default: begin
            state_nxt = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= S_IDLE;
         wr_addr_r <= ADDR_RESET;
         bytes_r <= COUNT_RESET;
         no_buf_r <= 1'b0;
         int_done_r <= 1'b0;
         int_hit_r <= 1'b0;
         ext_done_r <= 1'b0;
         ext_match_r <= 1'b0;
         ext_fail_r <= 1'b0;
         last_seen_r <= 1'b0;
         late_r <= 1'b0;
         drive_r <= 1'b0;
         settle_r <= 3'h0;
         wr_r <= '0;
         res_r <= '0;
         res_v_r <= 1'b0;
         ari_r <= 2'h0;
      end else if (clk_en) begin
         state_r <= state_nxt;
         wr_addr_r <= wr_addr_nxt;
         bytes_r <= bytes_nxt;
         no_buf_r <= no_buf_nxt;
         int_done_r <= int_done_nxt;
         int_hit_r <= int_hit_nxt;
         ext_done_r <= ext_done_nxt;
         ext_match_r <= ext_match_nxt;
         ext_fail_r <= ext_fail_nxt;
         last_seen_r <= last_seen_nxt;
         late_r <= late_nxt;
         drive_r <= drive_nxt;
         settle_r <= settle_nxt;
         wr_r <= wr_nxt;
         res_r <= res_nxt;
         res_v_r <= res_v_nxt;
         ari_r <= ari_nxt;
      end
   end

   // open-drain pins: data always zero, enable pulls low
   assign external_match_line_out = 1'b0;
   assign external_fail_line_out = 1'b0;
   assign external_match_line_oe = drive_r;
   assign external_fail_line_oe = drive_r;
   assign dma_wr = wr_r;
   assign result_valid = res_v_r;
   assign result = res_r;
   assign address_recognised_bits = ari_r;

   a_lines_together: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      external_match_line_oe == external_fail_line_oe)
      else $error("verdict lines driven apart");
   a_drive_first_word: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      external_match_line_oe |-> wr_r.valid)
      else $error("lines low without first word write");
   a_idle_released: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      state_r == S_IDLE |-> !external_match_line_oe)
      else $error("lines driven while idle");
   a_fail_wins: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      result_valid && result.ext_fail && !int_hit_r |-> !result.copy)
      else $error("failed external check copied frame");
   a_internal_copy: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      result_valid && int_hit_r && !no_buf_r |-> result.copy)
      else $error("internal match not copied");
   a_reclaim_uncopied: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      result_valid |-> result.reclaim == !result.copy)
      else $error("reclaim does not follow copy");
   a_decide_after_both: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      clk_en && state_r == S_CHECK && state_nxt == S_DONE
      |-> int_done_r && ext_done_r)
      else $error("decision before both checks");
   a_consecutive_words: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      clk_en && state_r == S_CHECK && !no_buf_r && wr_nxt.valid
      && !wr_r.valid |-> wr_addr_nxt == wr_addr_r + BYTES_PER_WORD)
      else $error("frame words not consecutive");
   a_no_buffer_addr: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      wr_r.valid && no_buf_r |-> wr_r.addr == NO_BUFFER_ADDR)
      else $error("no-buffer write off fixed address");
   a_express_only: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      result_valid && ext_match_r && !ext_fail_r && !int_hit_r
      && receive_copy_option == COPY_OPT_EXPRESS_ONLY
      |-> !result.copy && result.addr_recognised)
      else $error("express-only option copied external match");
   a_release_after: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      $fell(external_match_line_oe) |-> !external_match_line_oe [*2])
      else $error("lines not released after first word");
endmodule : frame_copy_check

// ---- hw/frame_copy_pkg.sv ----
// shared constants and carrier types for the frame copy decision block
package frame_copy_pkg;
   localparam int WORD_W = 16;
   localparam int ADDR_W = 16;
   localparam int LEN_W = 16;
   // address used for frame data when no receive buffer is free
   localparam logic [15:0] NO_BUFFER_ADDR = 16'h0200;
   // verdict must arrive this many bytes before the first buffer ends
   localparam logic [15:0] VERDICT_MARGIN_BYTES = 16'h0004;
   // bytes moved per receive word
   localparam logic [15:0] BYTES_PER_WORD = 16'h0002;
   // cycles in the check state before a low verdict line is trusted
   localparam logic [2:0] SYNC_SETTLE = 3'h4;
   // universal/local bit position inside the high specific address word
   localparam int UL_BIT_POS = 1;
   localparam int UL_BYTE_POS = 0;
   // receive copy option encodings
   localparam logic [1:0] COPY_OPT_NORMAL = 2'h0;
   localparam logic [1:0] COPY_OPT_EXPRESS_ONLY = 2'h1;
   // reset values
   localparam logic [15:0] ADDR_RESET = 16'h0000;
   localparam logic [15:0] COUNT_RESET = 16'h0000;

   // one receive DMA write as offered to the bus
   typedef struct packed {
      logic valid;
      logic [ADDR_W-1:0] addr;
      logic [WORD_W-1:0] data;
   } dma_write_t;

   // outcome of a finished frame
   typedef struct packed {
      logic copy;
      logic reclaim;
      logic addr_recognised;
      logic ext_fail;
      logic late;
   } frame_result_t;
endpackage : frame_copy_pkg

// ---- sim/echo_checker_model.sv ----
// behavioural external frame checker watching the adapter bus
`timescale 1ns/1ps
module echo_checker_model
   import frame_copy_pkg::*;
(
   input wire logic ref_clk, // bus clock
   input wire logic resetn, // async reset, active low
   input wire dma_write_t dma_wr, // observed bus write
   input wire logic bus_ready, // write accepted this edge
   input wire logic match_w, // match wire level
   input wire logic fail_w, // fail wire level
   input wire logic frame_done, // frame decided, release verdict
   input wire logic give_fail, // verdict kind to report
   output logic match_oe, // pull match low when high
   output logic fail_oe // pull fail low when high
);
   logic track_r;
   logic [ADDR_W-1:0] addr_r;
   logic hit;
   // no-buffer frames all land on the fixed address, so accept it too
   assign hit = dma_wr.valid && bus_ready && track_r &&
      (dma_wr.addr == addr_r || dma_wr.addr == NO_BUFFER_ADDR);
   // verdict right after the first traced word keeps well clear of the end
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         track_r <= 1'b0;
         addr_r <= ADDR_RESET;
         match_oe <= 1'b0;
         fail_oe <= 1'b0;
      end else if (frame_done) begin
         track_r <= 1'b0;
         match_oe <= 1'b0;
         fail_oe <= 1'b0;
      end else if (dma_wr.valid && bus_ready && !match_w && !fail_w &&
         !track_r) begin
         track_r <= 1'b1;
         addr_r <= dma_wr.addr + 16'h0002;
      end else if (hit) begin
         addr_r <= addr_r + 16'h0002;
         match_oe <= !give_fail;
         fail_oe <= give_fail;
      end
   end
endmodule : echo_checker_model

// ---- sim/external_frame_copy_check_test.sv ----
// self-checking bench for the frame copy decision block
`timescale 1ns/1ps
module external_frame_copy_check_test import frame_copy_pkg::*;;
   typedef struct packed {
      logic give_fail; logic dmatch; logic sta_b; logic [1:0] opt;
      logic bfree; logic [15:0] blen; logic stall;
      frame_result_t exp; frame_result_t mask;
   } row_t;
   localparam logic [15:0] BASE = 16'h0400;
   localparam int NW = 8;
   localparam logic [47:0] STA_A = 48'h1000_1234_5678;
   localparam logic [47:0] STA_B = 48'h1200_1234_5678;
   // expected result fields: copy, reclaim, recognised, fail, late
   localparam row_t ROWS [7] = '{
      '{1'b0, 1'b0, 1'b0, 2'h0, 1'b1, 16'h0100, 1'b0, 5'h14, 5'h1f},
      '{1'b1, 1'b0, 1'b0, 2'h0, 1'b1, 16'h0100, 1'b1, 5'h0a, 5'h1f},
      '{1'b1, 1'b1, 1'b0, 2'h0, 1'b1, 16'h0100, 1'b0, 5'h16, 5'h1f},
      '{1'b1, 1'b1, 1'b1, 2'h0, 1'b1, 16'h0100, 1'b0, 5'h16, 5'h1f},
      '{1'b0, 1'b0, 1'b0, 2'h1, 1'b1, 16'h0100, 1'b0, 5'h0c, 5'h1f},
      '{1'b0, 1'b0, 1'b0, 2'h0, 1'b1, 16'h0004, 1'b1, 5'h05, 5'h05},
      '{1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 16'h0100, 1'b0, 5'h04, 5'h04}};
   logic ref_clk = 0, resetn = 0, frame_start = 0, word_valid = 0;
   logic word_last = 0, dest_valid = 0, bus_ready = 1, stall = 0;
   logic give_fail = 0, buffer_free = 0, got_res = 0;
   logic [15:0] word_data = 0, buffer_len = 0;
   logic [47:0] dest_addr = 0, station_addr = 0;
   logic [1:0] opt = 0, arb, arb_cap;
   dma_write_t dma_wr;
   frame_result_t result, res_cap;
   logic m_out, m_oe, f_out, f_oe, p_m_oe, p_f_oe, word_ready, result_valid;
   int n_mismatch = 0, n_tests = 0, n_wr = 0;
   // pull-ups: a line is low only while some party drives it
   wire logic match_w = !(m_oe || p_m_oe);
   wire logic fail_w = !(f_oe || p_f_oe);

   frame_copy_check dut_u (.ref_clk(ref_clk), .resetn(resetn),
      .clk_en(1'b1), .frame_start(frame_start), .word_valid(word_valid),
      .word_data(word_data), .word_last(word_last),
      .dest_valid(dest_valid), .dest_addr(dest_addr),
      .station_addr(station_addr), .buffer_free(buffer_free),
      .buffer_base(BASE), .buffer_len(buffer_len),
      .receive_copy_option(opt), .bus_ready(bus_ready), .dma_wr(dma_wr),
      .external_match_line_in(match_w), .external_match_line_out(m_out),
      .external_match_line_oe(m_oe), .external_fail_line_in(fail_w),
      .external_fail_line_out(f_out), .external_fail_line_oe(f_oe),
      .word_ready(word_ready), .result_valid(result_valid),
      .result(result), .address_recognised_bits(arb));
   echo_checker_model partner_u (.ref_clk(ref_clk), .resetn(resetn),
      .dma_wr(dma_wr), .bus_ready(bus_ready), .match_w(match_w),
      .fail_w(fail_w), .frame_done(result_valid), .give_fail(give_fail),
      .match_oe(p_m_oe), .fail_oe(p_f_oe));

   initial forever #50 ref_clk = ~ref_clk;
   // stalling bus accepts every other cycle
   always @(negedge ref_clk) bus_ready <= stall ? ~bus_ready : 1'b1;

   task automatic chk1(input string nm, input logic e, input logic g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s exp %b got %b", nm, e, g);
      end
   endtask : chk1
   task automatic chk16(input string nm, input logic [15:0] e,
      input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask : chk16
   task automatic chkr(input frame_result_t e, input frame_result_t g,
      input frame_result_t m);
      n_tests++;
      if ((g & m) !== (e & m)) begin
         n_mismatch++;
         $display("MISMATCH result exp %b got %b", e & m, g & m);
      end
   endtask : chkr

   // every accepted write is checked where it lands
   always @(posedge ref_clk) begin
      if (resetn && dma_wr.valid && bus_ready) begin
         if (n_wr == 0) begin
            chk1("first_oe", 1'b1, m_oe & f_oe);
            chk1("line_out", 1'b0, m_out | f_out);
         end
         chk16("wr_addr", buffer_free ? BASE + 16'(2 * n_wr) :
            NO_BUFFER_ADDR, dma_wr.addr);
         chk16("wr_data", 16'h1040 + 16'(n_wr), dma_wr.data);
         n_wr++;
      end
      if (result_valid) begin
         got_res = 1'b1;
         res_cap = result;
         arb_cap = arb;
      end
   end

   task automatic send(input int i);
      @(negedge ref_clk);
      dest_valid = 1'b0;
      word_valid = 1'b1;
      word_data = 16'h1040 + 16'(i);
      word_last = (i == NW - 1);
      #1;
      while (!word_ready) begin
         @(negedge ref_clk);
         #1;
      end
   endtask : send

   task automatic rst_chk;
      chk1("rst_lines", 1'b0, m_oe | f_oe | dma_wr.valid);
      chk1("rst_result", 1'b0, result_valid);
   endtask : rst_chk

   task automatic run_frame(input row_t r);
      int i;
      @(negedge ref_clk);
      give_fail = r.give_fail;
      opt = r.opt;
      buffer_free = r.bfree;
      buffer_len = r.blen;
      stall = r.stall;
      station_addr = r.sta_b ? STA_B : STA_A;
      dest_addr = r.dmatch ? station_addr : 48'h0000_0000_0001;
      frame_start = 1'b1;
      n_wr = 0;
      got_res = 1'b0;
      @(negedge ref_clk);
      frame_start = 1'b0;
      dest_valid = 1'b1;
      for (i = 0; i <= NW; i++) send(i); // the word past the last is taken but not written
      @(negedge ref_clk);
      word_valid = 1'b0;
      for (i = 0; i < 300 && !got_res; i++) @(negedge ref_clk);
      chk1("got_res", 1'b1, got_res);
      chkr(r.exp, res_cap, r.mask);
      chk16("ari", {14'h0, {2{r.exp.addr_recognised}}}, {14'h0, arb_cap});
      if (r.mask === 5'h1f) chk16("n_writes", 16'(NW), 16'(n_wr));
      chk1("idle_lines", 1'b0, m_oe | f_oe);
      stall = 1'b0;
      repeat (4) @(negedge ref_clk);
   endtask : run_frame

   task automatic final_report;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : final_report

   initial begin
      #2000000;
      n_mismatch++;
      final_report;
   end

   initial begin
      repeat (2) @(negedge ref_clk);
      rst_chk;
      resetn = 1'b1;
      foreach (ROWS[k]) run_frame(ROWS[k]);
      // reset in mid-frame drops the lines and the pending write at once
      @(negedge ref_clk);
      frame_start = 1'b1;
      n_wr = 0;
      @(negedge ref_clk);
      frame_start = 1'b0;
      send(0);
      @(negedge ref_clk);
      chk1("mid_oe", 1'b1, m_oe & f_oe);
      resetn = 1'b0;
      word_valid = 1'b0;
      #1;
      rst_chk;
      repeat (2) @(negedge ref_clk);
      resetn = 1'b1;
      run_frame(ROWS[0]);
      final_report;
   end
endmodule : external_frame_copy_check_test
